// ==== common/dtd_map.vh ====
// constants for the data-transfer opcode decoder
`ifndef DTD_MAP_VH
`define DTD_MAP_VH
// register offsets (plain register port)
`define DTD_REG_CTRL        4'h0
`define DTD_REG_STATUS      4'h1
`define DTD_REG_OPCODE      4'h2
`define DTD_REG_MODRM       4'h3
`define DTD_REG_CLOCKS      4'h4
`define DTD_REG_EXTRA       4'h5
`define DTD_REG_COUNT       4'h6
// control fields
`define DTD_CTRL_EN_BIT     0
`define DTD_CTRL_EXTRA_LSB  1
`define DTD_CTRL_RST        8'h01
// status fields
`define DTD_ST_VALID_BIT    0
`define DTD_ST_ILLEGAL_BIT  1
`define DTD_ST_WORD_BIT     2
`define DTD_ST_MEM_BIT      3
`define DTD_ST_MODRM_BIT    4
`define DTD_ST_WAIT_BIT     5
// opcode bytes
`define DTD_OP_MOV_TO_SEG   8'h8E
`define DTD_OP_MOV_FROM_SEG 8'h8C
`define DTD_OP_TABLE_LOOKUP 8'hD7
`define DTD_OP_LOAD_EFF     8'h8D
`define DTD_OP_FAR_DATA     8'hC5
`define DTD_OP_FAR_EXTRA    8'hC4
`define DTD_OP_FLAGS_TO_ACC 8'h9F
`define DTD_OP_ACC_TO_FLAGS 8'h9E
// mod field value for register operand
`define DTD_MOD_REG         2'b11
// minimum clock counts
`define DTD_CLK_TO_SEG_REG  8'd2
`define DTD_CLK_TO_SEG_MEM  8'd13
`define DTD_CLK_FR_SEG_REG  8'd2
`define DTD_CLK_FR_SEG_MEM  8'd15
`define DTD_CLK_LOOKUP      8'd15
`define DTD_CLK_LOAD_EFF    8'd6
`define DTD_CLK_FAR_PTR     8'd26
`define DTD_CLK_FLAGS_ACC   8'd2
`define DTD_CLK_ACC_FLAGS   8'd3
`define DTD_CLK_ILLEGAL     8'd1
`endif

// ==== hw/dtd_opcode_table.v ====
// combinational lookup of opcode byte and operand byte
`timescale 1ns/1ps
`include "dtd_map.vh"
module dtd_opcode_table (
  // opcode in
  input  wire [7:0] opByte,
  input  wire [7:0] modByte,
  // decode results
  output reg        known,
  output reg        needsModrm,
  output reg        memAccess,
  output reg        illegalForm,
  output reg        isWord,
  output reg  [7:0] minClocks
);
  // register form when mod is 11
  function isRegForm;
    input [7:0] m;
    begin
      isRegForm = (m[7:6] == `DTD_MOD_REG);
    end
  endfunction

  // table decode; unknown bytes report zero clocks
  always @* begin
    known       = 1'b1;
    needsModrm  = 1'b0;
    memAccess   = 1'b0;
    illegalForm = 1'b0;
    isWord      = opByte[0]; // RULE_13
    minClocks   = 8'h00;
    case (opByte)
      `DTD_OP_MOV_TO_SEG: begin
        needsModrm = 1'b1;
        isWord     = 1'b1;
        memAccess  = ~isRegForm(modByte);
        minClocks  = isRegForm(modByte) ? `DTD_CLK_TO_SEG_REG : `DTD_CLK_TO_SEG_MEM; // RULE_01
      end
      `DTD_OP_MOV_FROM_SEG: begin
        needsModrm = 1'b1;
        isWord     = 1'b1;
        memAccess  = ~isRegForm(modByte);
        minClocks  = isRegForm(modByte) ? `DTD_CLK_FR_SEG_REG : `DTD_CLK_FR_SEG_MEM; // RULE_02
      end
      `DTD_OP_TABLE_LOOKUP: begin
        isWord    = 1'b0; // byte result into acc_low_byte
        memAccess = 1'b1;
        minClocks = `DTD_CLK_LOOKUP; // RULE_03
      end
      `DTD_OP_LOAD_EFF: begin
        needsModrm = 1'b1;
        isWord     = 1'b1;
        minClocks  = `DTD_CLK_LOAD_EFF; // RULE_04
      end
      `DTD_OP_FAR_DATA, `DTD_OP_FAR_EXTRA: begin
        needsModrm  = 1'b1;
        isWord      = 1'b1;
        // a refused register form never reaches the bus, so no slack is charged
        memAccess   = ~isRegForm(modByte);
        illegalForm = isRegForm(modByte); // RULE_05 RULE_06
        minClocks   = isRegForm(modByte) ? `DTD_CLK_ILLEGAL : `DTD_CLK_FAR_PTR; // RULE_05 RULE_06
      end
      `DTD_OP_FLAGS_TO_ACC: begin
        isWord    = 1'b0;
        minClocks = `DTD_CLK_FLAGS_ACC; // RULE_07
      end
      `DTD_OP_ACC_TO_FLAGS: begin
        isWord    = 1'b0;
        minClocks = `DTD_CLK_ACC_FLAGS; // RULE_08
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end
endmodule // dtd_opcode_table

// ==== hw/dtd_cycle_counter.v ====
// down counter that times execution-unit busy cycles
`timescale 1ns/1ps
`include "dtd_map.vh"
module dtd_cycle_counter #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst_b,
  // control
  input  wire             load,
  input  wire [WIDTH-1:0] loadValue,
  input  wire             stall,
  // state
  output wire             busy,
  output reg  [WIDTH-1:0] remaining
);
  assign busy = (remaining != {WIDTH{1'b0}});

  // load wins; stall freezes count (wait states or hold)
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remaining <= {WIDTH{1'b0}};
    end else if (load) begin
      remaining <= loadValue;
    end else if (busy && !stall) begin
      remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // dtd_cycle_counter

// ==== hw/dtd_decoder.v ====
// data-transfer opcode decoder: queue in, execution-unit timing out
`timescale 1ns/1ps
`include "dtd_map.vh"
// Function
// RULE_01 - segment load from reg/mem: 2/13 clocks
// RULE_02 - segment store to reg/mem: 2/15 clocks
// RULE_03 - table_lookup_byte replaces acc_low_byte, 15 clocks
// RULE_04 - load_effective_offset, no memory access, 6 clocks
// RULE_05 - load_far_pointer_data_seg memory only, 26 clocks
// RULE_06 - load_far_pointer_extra_seg memory only, 26 clocks
// RULE_07 - flags_to_high_acc takes 2 clocks
// RULE_08 - high_acc_to_flags takes 3 clocks
// RULE_09 - counts assume all bytes already queued
// RULE_10 - wait states or hold lengthen execution
// RULE_11 - memory forms may add one or two clocks
// RULE_12 - jump and call counts include target fetch
// RULE_13 - low width bit selects byte or word; the code fixes width per listed opcode, bit 0 only for others
// RULE_14 - hold execution until all bytes available
module dtd_decoder (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // prefetch queue side
  input  wire       queueValid,
  input  wire [7:0] queueByte,
  output wire       queueTake,
  // bus conditions from bus_interface_unit
  input  wire       busWait,
  input  wire       busHold,
  // execution unit side
  input  wire       execReady,
  output reg        execStart,
  output reg  [7:0] execOpcode,
  output reg  [7:0] execModrm,
  output reg  [7:0] execClocks,
  output reg        execWord,
  output reg        execIllegal,
  output wire       execBusy,
  // register port
  input  wire [3:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdData
);
  // states, one-hot
  localparam [3:0] ST_OPCODE = 4'b0001;
  localparam [3:0] ST_MODRM  = 4'b0010;
  localparam [3:0] ST_ISSUE  = 4'b0100;
  localparam [3:0] ST_EXEC   = 4'b1000;

  reg  [3:0] state;       // decode state
  reg  [3:0] next_state;  // next decode state
  reg  [7:0] ctrl;        // software control
  reg  [7:0] opLatch;     // captured opcode
  reg  [7:0] modLatch;    // captured operand byte
  reg  [7:0] issueCount;  // instructions issued
  reg  [7:0] lastClocks;  // clocks charged to last instruction
  reg        lastMem;     // last instruction touched memory
  wire       enable;      // decoder enabled by software
  wire [1:0] extraSlack;  // memory handoff allowance
  wire       tKnown;      // table: opcode recognised
  wire       tNeedsModrm; // table: operand byte follows
  wire       tMem;        // table: memory form
  wire       tIllegal;    // table: invalid mod form
  wire       tWord;       // table: word operand
  wire [7:0] tClocks;     // table: minimum clocks
  wire [7:0] chargeClocks;// clocks with memory slack
  wire       cntBusy;     // counter still running
  wire [7:0] cntLeft;     // counter remaining
  wire       loadCnt;     // start counter

  assign enable     = ctrl[`DTD_CTRL_EN_BIT];
  assign extraSlack = ctrl[`DTD_CTRL_EXTRA_LSB+1:`DTD_CTRL_EXTRA_LSB];

  // decode runs on the captured bytes; operand byte is zero until taken
  dtd_opcode_table uTable (
    .opByte      (opLatch),
    .modByte     (modLatch),
    .known       (tKnown),
    .needsModrm  (tNeedsModrm),
    .memAccess   (tMem),
    .illegalForm (tIllegal),
    .isWord      (tWord),
    .minClocks   (tClocks)
  );

  // memory forms may be charged one or two extra handoff clocks
  assign chargeClocks = tMem ? (tClocks + {6'h00, extraSlack}) : tClocks; // RULE_11

  // counter stalls while bus waits or hold is granted
  dtd_cycle_counter #(.WIDTH(8)) uCount (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .load      (loadCnt),
    .loadValue (chargeClocks),
    .stall     (busWait | busHold), // RULE_10
    .busy      (cntBusy),
    .remaining (cntLeft)
  );

  assign loadCnt  = (state == ST_ISSUE) && execReady;
  assign execBusy = cntBusy || (state != ST_OPCODE);

  // bytes are consumed only when present; absence stalls decode
  // a single-byte opcode must not swallow the next opcode as its operand
  assign queueTake = queueValid && enable &&
                     ((state == ST_OPCODE) ||
                      (state == ST_MODRM && tNeedsModrm)); // RULE_14 RULE_09

  // next-state logic
  always @* begin
    next_state = state;
    case (state)
      ST_OPCODE: begin
        if (queueTake) begin
          next_state = ST_MODRM;
        end
      end
      ST_MODRM: begin
        // single-byte opcodes skip the operand byte
        if (!tNeedsModrm) begin
          next_state = ST_ISSUE;
        end else if (queueTake) begin
          next_state = ST_ISSUE; // RULE_14
        end
      end
      ST_ISSUE: begin
        if (execReady) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // count covers the whole minimum; a branch target fetch
        // would be folded into the loaded count as well
        if (cntLeft <= 8'h01 && !(busWait | busHold)) begin
          next_state = ST_OPCODE; // RULE_12
        end
      end
      default: begin
        next_state = ST_OPCODE;
      end
    endcase
  end

  // state register
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_OPCODE;
    end else begin
      state <= next_state;
    end
  end

  // capture of opcode and operand byte
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      opLatch  <= 8'h00;
      modLatch <= 8'h00;
    end else if (queueTake && state == ST_OPCODE) begin
      opLatch  <= queueByte;
      modLatch <= 8'h00;
    end else if (queueTake && state == ST_MODRM) begin
      modLatch <= queueByte;
    end
  end

  // execution-unit outputs, held stable until next issue; execStart pulses for one cycle
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      execStart   <= 1'b0;
      execOpcode  <= 8'h00;
      execModrm   <= 8'h00;
      execClocks  <= 8'h00;
      execWord    <= 1'b0;
      execIllegal <= 1'b0;
    end else begin
      execStart <= loadCnt;
      if (loadCnt) begin
        execOpcode  <= opLatch;
        execModrm   <= modLatch;
        execClocks  <= chargeClocks; // RULE_01 RULE_02 RULE_03 RULE_04
        execWord    <= tWord; // RULE_13
        execIllegal <= tIllegal | ~tKnown; // RULE_05 RULE_06
      end
    end
  end

  // statistics visible to software
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      issueCount <= 8'h00;
      lastClocks <= 8'h00;
      lastMem    <= 1'b0;
    end else if (loadCnt) begin
      issueCount <= issueCount + 8'h01;
      lastClocks <= chargeClocks; // RULE_07 RULE_08
      lastMem    <= tMem;
    end
  end

  // control register write
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `DTD_CTRL_RST;
    end else if (regWrite && regAddr == `DTD_REG_CTRL) begin
      // slack above two is clipped; only 0..2 are meaningful
      ctrl <= {5'h00, (regWrData[2:1] == 2'b11) ? 2'b10 : regWrData[2:1], regWrData[0]};
    end
  end

  // read data, one cycle after the read strobe; unmapped reads zero
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `DTD_REG_CTRL:   regRdData <= ctrl;
        `DTD_REG_STATUS: regRdData <= {2'b00, (state == ST_MODRM && !queueValid),
                                       (state == ST_ISSUE || state == ST_MODRM),
                                       lastMem, execWord, execIllegal, execBusy};
        `DTD_REG_OPCODE: regRdData <= execOpcode;
        `DTD_REG_MODRM:  regRdData <= execModrm;
        `DTD_REG_CLOCKS: regRdData <= lastClocks;
        `DTD_REG_EXTRA:  regRdData <= {6'h00, extraSlack};
        `DTD_REG_COUNT:  regRdData <= issueCount;
        default:         regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule // dtd_decoder

// ==== verification/dtd_decoder_assertions.sv ====
// port checker for the data-transfer opcode decoder
`timescale 1ns/1ps
module dtd_decoder_assertions (
  // clock and reset
  input wire       ref_clk,
  input wire       rst_b,
  // queue side
  input wire       queueValid,
  input wire       queueTake,
  // execution side
  input wire       execStart,
  input wire [7:0] execOpcode,
  input wire [7:0] execModrm,
  input wire [7:0] execClocks,
  input wire       execIllegal,
  input wire       execBusy,
  // register port
  input wire [3:0] regAddr,
  input wire       regRead,
  input wire [7:0] regRdData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire regForm = execModrm[7:6] == 2'b11; // register operand form
  a_start_single: assert property (execStart |=> !execStart)
    else $error("issue pulse longer than one cycle");
  a_take_gated: assert property (queueTake |-> queueValid && !execStart)
    else $error("byte taken from empty queue or during issue");
  a_lookup_cnt: assert property (execStart && execOpcode == 8'hD7 |->
    execClocks >= 8'h0F && execClocks <= 8'h11) else $error("lookup count wrong");
  a_far_mem: assert property (execStart && !regForm &&
    (execOpcode & 8'hFE) == 8'hC4 |-> !execIllegal && execClocks >= 8'h1A &&
    execClocks <= 8'h1C) else $error("far pointer load count wrong");
  a_flags_acc: assert property (execStart && execOpcode == 8'h9F |->
    execClocks == 8'h02 && !execIllegal) else $error("flag copy count wrong");
  a_acc_flags: assert property (execStart && execOpcode == 8'h9E |->
    execClocks == 8'h03 && !execIllegal) else $error("flag load count wrong");
  a_load_eff: assert property (execStart && execOpcode == 8'h8D |->
    execClocks == 8'h06) else $error("offset load count wrong");
  a_seg_reg: assert property (execStart && regForm &&
    (execOpcode & 8'hFD) == 8'h8C |-> execClocks == 8'h02)
    else $error("segment move count wrong");
  a_far_bad: assert property (execStart && regForm &&
    (execOpcode & 8'hFE) == 8'hC4 |-> execIllegal && execClocks == 8'h01)
    else $error("register far pointer not refused");
  a_busy_run: assert property (execStart && execClocks >= 8'h02 |->
    execBusy [*2]) else $error("busy dropped early");
  a_rd_quiet: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside read answer");
  a_rd_unmapped: assert property (regRead && regAddr > 4'h6 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule // dtd_decoder_assertions

bind dtd_decoder dtd_decoder_assertions i_chk (.ref_clk, .rst_b, .queueValid,
  .queueTake, .execStart, .execOpcode, .execModrm, .execClocks, .execIllegal,
  .execBusy, .regAddr, .regRead, .regRdData);

// ==== verification/dtd_queue_model.sv ====
// prefetch queue model: hands bytes to the decoder one per take
`timescale 1ns/1ps
module dtd_queue_model (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // decoder side
  input  wire       queueTake,
  output wire       queueValid,
  output wire [7:0] queueByte
);
  reg     [7:0] mem [0:255]; // queued bytes
  integer       head = 0;    // next byte out
  integer       tail = 0;    // next free slot
  initial mem[255] = 8'hA5;  // filler before the first byte
  // bytes are queued before needed, so no fetch delay adds in
  assign queueValid = head != tail;
  // empty queue shows the inverse of the last byte, never stale data
  assign queueByte = queueValid ? mem[head[7:0]] : ~mem[head[7:0] - 8'h01];
  // reset flushes whatever was still queued
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) head <= tail;
    else if (queueTake && queueValid) head <= head + 1;
  end
  // the bench appends bytes off the clock edge
  task push(input logic [7:0] b);
    mem[tail[7:0]] = b;
    tail = tail + 1;
  endtask
endmodule // dtd_queue_model

// ==== verification/data_transfer_opcode_decoder_tb_top.sv ====
// self-checking bench for the data-transfer opcode decoder
`timescale 1ns/1ps
module data_transfer_opcode_decoder_tb_top;
  typedef struct packed {
    logic [7:0] op;  // opcode byte
    logic [7:0] m;   // operand byte
    logic       nm;  // operand byte follows
    logic [7:0] clk; // charged clocks
    logic       ill; // illegal form
  } dtd_row_t;
  // operand 0xC0 is a register form, 0x06 a memory form
  dtd_row_t rows [12] = '{
    '{8'h8E, 8'hC0, 1'h1, 8'h02, 1'h0}, '{8'h8E, 8'h06, 1'h1, 8'h0D, 1'h0},
    '{8'h8C, 8'hC0, 1'h1, 8'h02, 1'h0}, '{8'h8C, 8'h06, 1'h1, 8'h0F, 1'h0},
    '{8'hD7, 8'h00, 1'h0, 8'h0F, 1'h0}, '{8'h8D, 8'h06, 1'h1, 8'h06, 1'h0},
    '{8'hC5, 8'h06, 1'h1, 8'h1A, 1'h0}, '{8'hC4, 8'h06, 1'h1, 8'h1A, 1'h0},
    '{8'hC5, 8'hC0, 1'h1, 8'h01, 1'h1}, '{8'hC4, 8'hC0, 1'h1, 8'h01, 1'h1},
    '{8'h9F, 8'h00, 1'h0, 8'h02, 1'h0}, '{8'h9E, 8'h00, 1'h0, 8'h03, 1'h0}};
  reg        ref_clk = 1'h0, rst_b = 1'h0, regWrite = 1'h0, regRead = 1'h0;
  reg        busWait = 1'h0, busHold = 1'h0, execReady = 1'h1;
  reg  [3:0] regAddr = 4'h0;
  reg  [7:0] regWrData = 8'h00;
  wire       queueValid, queueTake, execStart, execWord, execIllegal, execBusy;
  wire [7:0] queueByte, execOpcode, execModrm, execClocks, regRdData;
  integer    err_total = 0, n_checks = 0, i, cnt, base [12];
  dtd_decoder i_dut (.ref_clk, .rst_b, .queueValid, .queueByte, .queueTake,
    .busWait, .busHold, .execReady, .execStart, .execOpcode, .execModrm,
    .execClocks, .execWord, .execIllegal, .execBusy, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData);
  dtd_queue_model i_q (.ref_clk, .rst_b, .queueTake, .queueValid, .queueByte);
  always #20 ref_clk = ~ref_clk; // 25 MHz
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge ref_clk);
    regWrite <= 1'h0;
  endtask
  // read answer stands only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge ref_clk);
    regRead <= 1'h0;
    #1 chk(regRdData, e);
  endtask
  task feed(input logic [7:0] op, input logic [7:0] m, input logic nm);
    @(posedge ref_clk);
    #1 i_q.push(op);
    if (nm) i_q.push(m);
  endtask
  // wait for issue, then count busy cycles while stalling w/h cycles
  task done(input integer w, input integer h);
    cnt = 0;
    while (execStart !== 1'h1 && cnt < 60) begin
      @(posedge ref_clk);
      #1 cnt++;
    end
    chk({7'h0, execStart}, 8'h01);
    cnt = 0;
    while (execBusy === 1'h1 && cnt < 200) begin
      @(posedge ref_clk);
      busWait <= cnt < w;
      busHold <= cnt < h;
      #1 cnt++;
    end
  endtask
  // count takes (sel) or issues over n cycles
  task idle(input integer n, input logic sel);
    cnt = 0;
    repeat (n) begin
      @(negedge ref_clk);
      cnt += sel ? queueTake : execStart;
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // guard against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'h1;
    rd(4'h0, 8'h01);
    chk(execClocks, 8'h00);
    for (i = 0; i < 12; i++) begin
      feed(rows[i].op, rows[i].m, rows[i].nm);
      done(0, 0);
      base[i] = cnt;
      chk(execOpcode, rows[i].op);
      chk(execClocks, rows[i].clk);
      chk({7'h0, execIllegal}, {7'h0, rows[i].ill});
      // in this table every operand-byte form moves a word, the rest a byte
      chk({7'h0, execWord}, {7'h0, rows[i].nm});
    end
    rd(4'h6, 8'h0C);
    // stalls stretch execution by exactly the stalled cycles
    feed(8'h9E, 8'h00, 1'h0);
    done(3, 0);
    chk(cnt[7:0], base[11][7:0] + 8'h03);
    feed(8'h9F, 8'h00, 1'h0);
    done(0, 2);
    chk(cnt[7:0], base[10][7:0] + 8'h02);
    // operand byte withheld, then execution unit not ready
    @(posedge ref_clk);
    execReady <= 1'h0;
    feed(8'h8D, 8'h00, 1'h0);
    idle(8, 1'h0);
    chk(cnt[7:0], 8'h00);
    // status: busy, awaiting operand, queue empty
    rd(4'h1, 8'h31);
    i_q.push(8'h06);
    idle(8, 1'h0);
    chk(cnt[7:0], 8'h00);
    @(posedge ref_clk);
    execReady <= 1'h1;
    done(0, 0);
    chk(execClocks, 8'h06);
    // disabled decoder refuses queue bytes
    wr(4'h0, 8'h00);
    feed(8'h9F, 8'h00, 1'h0);
    idle(6, 1'h1);
    chk(cnt[7:0], 8'h00);
    wr(4'h0, 8'h01);
    done(0, 0);
    chk(execOpcode, 8'h9F);
    // memory handoff slack on a memory form
    wr(4'h0, 8'h05);
    rd(4'h5, 8'h02);
    feed(8'hC5, 8'h06, 1'h1);
    done(0, 0);
    chk(execClocks, 8'h1C);
    rd(4'h2, 8'hC5);
    rd(4'h3, 8'h06);
    rd(4'h4, 8'h1C);
    wr(4'h0, 8'h07);
    rd(4'h5, 8'h02);
    wr(4'hF, 8'hAA);
    rd(4'hF, 8'h00);
    rd(4'h0, 8'h05);
    // two single-byte opcodes queued together stay two instructions
    feed(8'h9E, 8'h9F, 1'h1);
    done(0, 0);
    chk(execOpcode, 8'h9E);
    done(0, 0);
    chk(execOpcode, 8'h9F);
    // an opcode outside this group issues refused with no clocks
    feed(8'hF4, 8'h00, 1'h0);
    done(0, 0);
    chk({7'h0, execIllegal}, 8'h01);
    chk(execClocks, 8'h00);
    summarize();
  end
endmodule // data_transfer_opcode_decoder_tb_top
